// ---- rtl/irq_status_pkg.sv ----
// Register map, field positions and reset values of the interrupt status block
package irq_status_pkg;
	localparam int ADDR_W = 12;
	localparam int SRC_N = 7;
	localparam logic [11:0] RAW_FLAGS_OFF = 12'h03c;
	localparam logic [11:0] MASKED_FLAGS_OFF = 12'h040;
	localparam logic [11:0] FLAG_CLEAR_OFF = 12'h044;
	localparam logic [11:0] MASK_OFF = 12'h038;
	localparam logic [11:0] IDENT_FOUR_OFF = 12'hfd0;
	localparam logic [11:0] LEVEL_OFF = 12'h048;
	// Lowest flag bit; flags occupy [10:4]
	localparam int FLAG_LSB = 4;
	localparam int RX_LEVEL_BIT = 4;
	localparam int TX_LEVEL_BIT = 5;
	localparam int RX_TIMEOUT_BIT = 6;
	localparam int FRAMING_BIT = 7;
	localparam int PARITY_BIT = 8;
	localparam int BREAK_BIT = 9;
	localparam int OVERRUN_BIT = 10;
	localparam logic [3:0] RAW_LOW_RESET = 4'hf;
	localparam logic [6:0] FLAGS_RESET = 7'h00;
	localparam logic [6:0] MASK_RESET = 7'h00;
	// Identification byte: arbitrary neutral value
	localparam logic [7:0] IDENT_FIELD_FOUR = 8'h5a;
endpackage

// ---- rtl/level_cross_detect.sv ----
// Detects the fill level passing through a trigger level
`timescale 1ns/100ps
module level_cross_detect #(
	parameter int LVL_W = 5
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [LVL_W-1:0] fill_level,
	input wire logic [LVL_W-1:0] trigger_level,
	input wire logic rising,
	output logic crossed
);
	logic at_reg;
	logic at_now;

	// Rising: at or above; falling: at or below
	assign at_now = rising ? (fill_level >= trigger_level) : (fill_level <= trigger_level);
	// Only a transition into the triggered region counts
	assign crossed = at_now && !at_reg;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			at_reg <= 1'b1;
		end else begin
			at_reg <= at_now;
		end
	end
endmodule

// ---- rtl/irq_flag_bank.sv ----
// Sticky event flags with write-one-to-clear, set winning over clear
`timescale 1ns/100ps
module irq_flag_bank #(
	parameter int N = 7
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [N-1:0] set_pulse,
	input wire logic [N-1:0] clear_pulse,
	output logic [N-1:0] flags
);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flags <= irq_status_pkg::FLAGS_RESET;
		end else begin
			flags <= (flags & ~clear_pulse) | set_pulse;
		end
	end
endmodule

// ---- rtl/irq_status_ctrl.sv ----
// Interrupt status, mask and clear registers on a classic Wishbone slave
// Operation
// R1: Reading the raw status register returns every flag before masking and writing it does nothing.
// R2: Raw flags sit at overrun 10, break 9, parity 8, framing 7, time-out 6, transmit 5, receive 4.
// R3: A raw flag shows its condition regardless of its mask bit.
// R4: Raw status bits 3:0 are read-only and read as all ones from reset.
// R5: Reading the masked status register returns the masked flags and writing it does nothing.
// R6: Masked status uses the raw bit positions and resets to zero.
// R7: Writing one to a clear bit clears that raw flag and so its masked flag at once; the code clears only with wb_sel_i[1:0] both set.
// R8: Writing zero to a clear bit leaves that flag untouched.
// R9: Clear bits line up with the status bit positions.
// R10: Software leaves reserved upper bits alone and does not rely on their value.
// R11: The fourth identification register is a constant with its byte in bits 7:0, zero above.
// R12: A mask bit of one passes its raw flag to the interrupt and masked status, zero blocks it.
// R13: Transmit and receive flags are set when the fill level crosses the trigger, not while it sits.
// R14: The interrupt output is high while any masked flag is one.
`timescale 1ns/100ps
module irq_status_ctrl #(
	parameter int LVL_W = 5
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic overrun_event,
	input wire logic break_event,
	input wire logic parity_event,
	input wire logic framing_event,
	input wire logic rx_timeout_event,
	input wire logic [LVL_W-1:0] tx_fill,
	input wire logic [LVL_W-1:0] rx_fill,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////////
	logic [6:0] interrupt_mask_reg;
	logic [6:0] mask_next;
	logic [6:0] flags_next;
	logic [LVL_W-1:0] tx_trig_reg;
	logic [LVL_W-1:0] rx_trig_reg;
	logic [6:0] flags;
	logic [6:0] set_pulse;
	logic [6:0] clear_pulse;
	logic [6:0] masked;
	logic tx_cross;
	logic rx_cross;
	logic req;
	logic wr;
	logic [31:0] rd_next;

	function automatic logic [31:0] place_flags(input logic [6:0] f);
		place_flags = {21'h000000, f, 4'h0};
	endfunction

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i;

	////////////////////////////////////////////////////////////////////////////
	// Event sources
	level_cross_detect #(.LVL_W(LVL_W)) u_tx_cross (
		.clk_sys(clk_sys),
		.rst(rst),
		.fill_level(tx_fill),
		.trigger_level(tx_trig_reg),
		.rising(1'b0),
		.crossed(tx_cross)
	);

	level_cross_detect #(.LVL_W(LVL_W)) u_rx_cross (
		.clk_sys(clk_sys),
		.rst(rst),
		.fill_level(rx_fill),
		.trigger_level(rx_trig_reg),
		.rising(1'b1),
		.crossed(rx_cross)
	);

	// Set is independent of mask; see R3 see R13
	assign set_pulse = {overrun_event, break_event, parity_event, framing_event,
		rx_timeout_event, tx_cross, rx_cross};

	// Write-one clears only with wb_sel_i[1:0] both set, zero bits untouched; see R7 see R8 see R9
	assign clear_pulse = (wr && hit(wb_adr_i, irq_status_pkg::FLAG_CLEAR_OFF) && wb_sel_i[1]
		&& wb_sel_i[0]) ? wb_dat_i[10:4] : 7'h00;

	irq_flag_bank #(.N(7)) u_flags (
		.clk_sys(clk_sys),
		.rst(rst),
		.set_pulse(set_pulse),
		.clear_pulse(clear_pulse),
		.flags(flags)
	);

	assign masked = flags & interrupt_mask_reg; // see R12

	// Next flag state, so the registered interrupt tracks the flags without lag
	assign flags_next = (flags & ~clear_pulse) | set_pulse;

	////////////////////////////////////////////////////////////////////////////
	// Software-written control
	always_comb begin
		mask_next = interrupt_mask_reg;
		if (wr && hit(wb_adr_i, irq_status_pkg::MASK_OFF)) begin
			if (wb_sel_i[0]) begin
				mask_next[3:0] = wb_dat_i[7:4];
			end
			if (wb_sel_i[1]) begin
				mask_next[6:4] = wb_dat_i[10:8];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			interrupt_mask_reg <= irq_status_pkg::MASK_RESET;
		end else begin
			interrupt_mask_reg <= mask_next; // see R12
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_trig_reg <= LVL_W'(8);
			rx_trig_reg <= LVL_W'(8);
		end else if (wr && hit(wb_adr_i, irq_status_pkg::LEVEL_OFF)) begin
			if (wb_sel_i[0]) begin
				tx_trig_reg <= wb_dat_i[LVL_W-1:0];
			end
			if (wb_sel_i[1]) begin
				rx_trig_reg <= wb_dat_i[8+LVL_W-1:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux; writes to status registers fall through with no effect
	always_comb begin
		rd_next = 32'h00000000;
		unique case (wb_adr_i)
			irq_status_pkg::RAW_FLAGS_OFF: begin
				rd_next = place_flags(flags) | {28'h0000000, irq_status_pkg::RAW_LOW_RESET}; // see R1 see R2 see R4
			end
			irq_status_pkg::MASKED_FLAGS_OFF: begin
				rd_next = place_flags(masked); // see R5 see R6
			end
			irq_status_pkg::MASK_OFF: begin
				rd_next = place_flags(interrupt_mask_reg);
			end
			irq_status_pkg::LEVEL_OFF: begin
				rd_next = {16'h0000, 8'(rx_trig_reg), 8'(tx_trig_reg)};
			end
			irq_status_pkg::IDENT_FOUR_OFF: begin
				rd_next = {24'h000000, irq_status_pkg::IDENT_FIELD_FOUR}; // see R11
			end
			default: begin
				rd_next = 32'h00000000;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? rd_next : 32'h00000000;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(flags_next & mask_next); // see R14
		end
	end

	////////////////////////////////////////////////////////////////////////////
	chk_ack_one_cycle: assert property (@(posedge clk_sys) disable iff (rst) // see R1
		wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

	chk_raw_low_ones: assert property (@(posedge clk_sys) disable iff (rst) // see R4
		(req && !wb_we_i && wb_adr_i == irq_status_pkg::RAW_FLAGS_OFF)
		|=> wb_dat_o[3:0] == 4'hf) else $error("raw low bits not ones");

	chk_raw_read_flags: assert property (@(posedge clk_sys) disable iff (rst) // see R2
		(req && !wb_we_i && wb_adr_i == irq_status_pkg::RAW_FLAGS_OFF)
		|=> wb_dat_o[10:4] == $past(flags)) else $error("raw read mismatch");

	chk_masked_read: assert property (@(posedge clk_sys) disable iff (rst) // see R6
		(req && !wb_we_i && wb_adr_i == irq_status_pkg::MASKED_FLAGS_OFF)
		|=> wb_dat_o == place_flags($past(masked))) else $error("masked read mismatch");

	chk_clear_one: assert property (@(posedge clk_sys) disable iff (rst) // see R7
		(clear_pulse[6] && !set_pulse[6]) |=> !flags[6]) else $error("clear failed");

	chk_clear_zero: assert property (@(posedge clk_sys) disable iff (rst) // see R8
		(!clear_pulse[0] && flags[0]) |=> flags[0]) else $error("flag lost");

	chk_set_unmasked: assert property (@(posedge clk_sys) disable iff (rst) // see R3
		set_pulse[5] |=> flags[5]) else $error("set lost");

	chk_irq_level: assert property (@(posedge clk_sys) disable iff (rst) // see R14
		irq == |masked) else $error("irq disagrees with masked flags");

	chk_ident_read: assert property (@(posedge clk_sys) disable iff (rst) // see R11
		(req && wb_adr_i == irq_status_pkg::IDENT_FOUR_OFF)
		|=> wb_dat_o[31:8] == 24'h000000) else $error("ident upper bits set");

	chk_no_cross_sit: assert property (@(posedge clk_sys) disable iff (rst) // see R13
		(rx_fill >= rx_trig_reg) ##1 ((rx_fill >= rx_trig_reg) && $stable(rx_trig_reg))
		|-> !rx_cross) else $error("level sitting set flag");

	chk_raw_write_none: assert property (@(posedge clk_sys) disable iff (rst) // see R1
		(wr && hit(wb_adr_i, irq_status_pkg::RAW_FLAGS_OFF) && set_pulse == 7'h00)
		|=> flags == $past(flags)) else $error("raw write changed flags");

	chk_masked_write_none: assert property (@(posedge clk_sys) disable iff (rst) // see R5
		(wr && hit(wb_adr_i, irq_status_pkg::MASKED_FLAGS_OFF) && set_pulse == 7'h00)
		|=> flags == $past(flags)) else $error("masked write changed flags");

	chk_clear_lanes: assert property (@(posedge clk_sys) disable iff (rst) // see R9
		(wr && hit(wb_adr_i, irq_status_pkg::FLAG_CLEAR_OFF) && wb_sel_i[1:0] == 2'b11
		&& set_pulse == 7'h00)
		|=> flags == ($past(flags) & ~$past(wb_dat_i[10:4]))) else $error("clear lanes wrong");

	chk_dat_idle_zero: assert property (@(posedge clk_sys) disable iff (rst) // see R1
		!wb_ack_o |-> wb_dat_o == 32'h00000000) else $error("read data outside ack");

	chk_tx_cross_entry: assert property (@(posedge clk_sys) disable iff (rst) // see R13
		tx_cross |-> tx_fill <= tx_trig_reg) else $error("tx crossing outside level");

	chk_ident_low: assert property (@(posedge clk_sys) disable iff (rst) // see R11
		(req && wb_adr_i == irq_status_pkg::IDENT_FOUR_OFF)
		|=> wb_dat_o[7:0] == irq_status_pkg::IDENT_FIELD_FOUR) else $error("ident byte wrong");

	cov_clear_write: cover property (@(posedge clk_sys) disable iff (rst) |clear_pulse);
	cov_mask_write: cover property (@(posedge clk_sys) disable iff (rst)
		wr && hit(wb_adr_i, irq_status_pkg::MASK_OFF));
	cov_tx_cross: cover property (@(posedge clk_sys) disable iff (rst) tx_cross);
	cov_irq_rise: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));
	cov_rx_cross: cover property (@(posedge clk_sys) disable iff (rst) rx_cross);
endmodule

// ---- test/irq_status_ctrl_tb.sv ----
// Self-checking bench for the interrupt status, mask and clear registers
`timescale 1ns/100ps
module irq_status_ctrl_tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [11:0] wb_adr_i = 12'h000;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [4:0] ev = 5'h00;
	logic [4:0] tx_fill = 5'h08;
	logic [4:0] rx_fill = 5'h08;
	logic irq;
	int miscompares = 0;
	int n_checks = 0;
	int flags_m = 0;
	int mask_m = 0;
	logic [31:0] q;
	always #50 clk_sys = ~clk_sys;
	irq_status_ctrl #(.LVL_W(5)) irq_status_ctrl_inst (.clk_sys(clk_sys), .rst(rst),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.overrun_event(ev[4]), .break_event(ev[3]), .parity_event(ev[2]),
		.framing_event(ev[1]), .rx_timeout_event(ev[0]), .tx_fill(tx_fill),
		.rx_fill(rx_fill), .irq(irq));
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			miscompares++;
		end
	endtask
	// Single classic cycle; holds everything until ack is sampled high
	task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (n >= 20) begin
			$display("wrong value ack expected 1 seen none");
			miscompares++;
		end
	endtask
	task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(name, exp, q);
	endtask
	task automatic check_all();
		rd("raw", irq_status_pkg::RAW_FLAGS_OFF, 32'(flags_m << 4) | 32'hf);
		rd("masked", irq_status_pkg::MASKED_FLAGS_OFF, 32'((flags_m & mask_m) << 4));
		chk("irq", 32'((flags_m & mask_m) != 0), 32'(irq));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int r;
		void'($urandom(41771));
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		check_all();
		rd("ident", irq_status_pkg::IDENT_FOUR_OFF, 32'(irq_status_pkg::IDENT_FIELD_FOUR));
		rd("unmapped", 12'h100, 32'h0);
		for (int i = 0; i < 8; i++) begin
			r = $urandom;
			@(posedge clk_sys);
			ev <= r[4:0];
			@(posedge clk_sys);
			ev <= 5'h00;
			flags_m = flags_m | (int'(r[4:0]) << 2);
			// Writes to the read-only views must change nothing
			bus(1'b1, irq_status_pkg::RAW_FLAGS_OFF, $urandom & 32'h7f0);
			bus(1'b1, irq_status_pkg::MASKED_FLAGS_OFF, $urandom & 32'h7f0);
			bus(1'b1, irq_status_pkg::IDENT_FOUR_OFF, $urandom & 32'h7f0);
			r = $urandom & 32'h7f0;
			bus(1'b1, irq_status_pkg::MASK_OFF, r);
			mask_m = (r >> 4) & 32'h7f;
			check_all();
			r = $urandom & 32'h7f0;
			bus(1'b1, irq_status_pkg::FLAG_CLEAR_OFF, r);
			flags_m = flags_m & ~((r >> 4) & 32'h7f);
			check_all();
		end
		// Level crossings: leave the trigger, then re-enter it
		@(posedge clk_sys);
		tx_fill <= 5'h09;
		rx_fill <= 5'h07;
		repeat (3) @(posedge clk_sys);
		tx_fill <= 5'h08;
		rx_fill <= 5'h08;
		repeat (4) @(posedge clk_sys);
		flags_m = flags_m | 3;
		check_all();
		bus(1'b1, irq_status_pkg::FLAG_CLEAR_OFF, 32'h30);
		flags_m = flags_m & ~3;
		repeat (6) @(posedge clk_sys);
		check_all();
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		finish_test();
	end
endmodule
